// ### rtl/pocr_map.svh
/*
 * Register offsets, field positions, reset values and encodings of the
 * PLL output configuration registers.
 * Assumes an 8-bit register bus with byte-wide registers at the offsets below.
 */
`ifndef POCR_MAP_SVH
`define POCR_MAP_SVH

// Register offsets
`define POCR_OFS_LOCK_RES 8'h0d
`define POCR_OFS_DIV_SEL 8'h0e
`define POCR_OFS_TRIM 8'h0f
`define POCR_OFS_ENA_MODE 8'h10
`define POCR_OFS_PHASE_CMD 8'h11
`define POCR_OFS_STATUS 8'h12

// Field positions
`define POCR_LOCK_RES_MSB 7
`define POCR_LOCK_RES_LSB 6
`define POCR_TRIM_PRI_MSB 7
`define POCR_TRIM_PRI_LSB 4
`define POCR_TRIM_SEC_MSB 3
`define POCR_TRIM_SEC_LSB 0
`define POCR_OUT_EN_MSB 3
`define POCR_OUT_EN_LSB 0
`define POCR_LOCK_MODE_MSB 6
`define POCR_LOCK_MODE_LSB 4
`define POCR_PHASE_SRC_BIT 7
`define POCR_STEP_CMD_BIT 0
`define POCR_STEP_DIR_BIT 1
`define POCR_STEP_SEL_MSB 3
`define POCR_STEP_SEL_LSB 2

// Reset values
`define POCR_RST_LOCK_RES 2'h0
`define POCR_RST_DIV_SEL 8'h00
`define POCR_RST_TRIM 4'h0
`define POCR_RST_OUT_EN 4'h1
`define POCR_RST_LOCK_MODE 3'h0
`define POCR_RST_PHASE_SRC 1'h0
`define POCR_RST_PHASE_CMD 4'h0

// Lock tolerance codes, in ppm
`define POCR_LOCK_PPM_0 16'd250
`define POCR_LOCK_PPM_1 16'd1000
`define POCR_LOCK_PPM_2 16'd4000
`define POCR_LOCK_PPM_3 16'd16000

// Divider input select codes
`define POCR_DSEL_PREMUX 2'h0

// Trim delay per step, in ps
`define POCR_TRIM_STEP_PS 16'd70
`define POCR_TRIM_70 3'h1
`define POCR_TRIM_140 3'h2
`define POCR_TRIM_280 3'h4

// Phase step size, in degrees of the VCO
`define POCR_PHASE_STEP_DEG 8'd45

`endif

// ### rtl/pocr_pkg.sv
/*
 * Types shared by the PLL output configuration block.
 * Assumes pocr_map.svh for all numeric values.
 */
package pocr_pkg;

	typedef enum logic [2:0] {
		POCR_LOCK_NORMAL = 3'h0,
		POCR_LOCK_STICKY = 3'h1,
		POCR_LOCK_NORMAL_ALT = 3'h4
	} pocr_lock_mode_e;

	// Decoded trim control for one output
	typedef struct packed {
		logic rise_edge;
		logic fall_edge;
		logic [15:0] delay_ps;
	} pocr_trim_s;

	// One dynamic phase step command
	typedef struct packed {
		logic step;
		logic earlier;
		logic [1:0] target;
	} pocr_phase_step_s;

endpackage : pocr_pkg

// ### rtl/pocr_regs.sv
/*
 * PLL output section configuration registers: lock-detector resolution,
 * cascade input selects of the four output dividers, edge trim of the
 * primary and secondary outputs, output enables, lock mode and dynamic
 * phase control ownership, with a register-driven phase step command.
 * Assumes an 8-bit register bus with a Wishbone classic handshake,
 * synchronous inputs and the analog PLL core outside this block.
 */
`include "pocr_map.svh"

// Operation
// - Lock resolution field picks 250, 1000, 4000 or 16000 ppm; resets 00.
// - Primary divider input: own pre-mux, fourth, second or third divider.
// - Second divider input: own pre-mux, first, fourth or third divider.
// - Third divider input: own pre-mux, first, second or fourth divider.
// - Fourth divider input: own pre-mux, first, second or third divider.
// - Primary trim top bit picks edge: 0 falling, 1 rising; resets 0000.
// - Lower trim bits one-hot: 70, 140 or 280 ps on selected edge.
// - Secondary output has identical trim field encoding, reset 0000.
// - Each enable fuse ORed with its enable port; reset enables primary only.
// - Lock mode 000 normal, 001 sticky, 100 alternate normal; others unsupported.
// - Sticky mode holds lock high until PLL reset or power down.
// - Phase source bit: 0 register bus controls phase, 1 external ports.
// - Register phase step fires on falling edge of command bit, 45 degrees.
module pocr_regs (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Register bus
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [7:0] i_wb_dat,
	output logic [7:0] o_wb_dat,
	output logic o_wb_ack,
	// PLL core status and control
	input wire logic i_lock_raw,
	input wire logic i_pll_rst,
	input wire logic i_pll_pd,
	output logic o_lock,
	output logic [15:0] o_lock_tol_ppm,
	// Output dividers and outputs
	output logic [19:0] o_div_src,
	input wire logic [3:0] i_out_en_port,
	output logic [3:0] o_out_en,
	output pocr_pkg::pocr_trim_s o_trim_primary,
	output pocr_pkg::pocr_trim_s o_trim_secondary,
	// Dynamic phase control
	input wire logic i_phase_step_port,
	input wire logic i_phase_dir_port,
	input wire logic [1:0] i_phase_sel_port,
	output logic o_phase_from_ports,
	output pocr_pkg::pocr_phase_step_s o_phase_step
);

	timeunit 1ns;
	timeprecision 1ns;

	logic [1:0] lock_resolution_select;
	logic [1:0] div_a_input_select;
	logic [1:0] div_b_input_select;
	logic [1:0] div_c_input_select;
	logic [1:0] div_d_input_select;
	logic [3:0] primary_out_edge_trim;
	logic [3:0] secondary_out_edge_trim;
	logic [3:0] output_enable_fuses;
	pocr_pkg::pocr_lock_mode_e lock_mode_select;
	logic phase_control_source;
	logic [3:0] phase_step_command;
	logic lock_held;
	logic step_port_q;
	logic wr_en;
	logic rd_en;
	logic [7:0] next_rd_dat;
	logic [7:0] div_sel_all;
	logic [3:0] next_div_cmd;
	logic wr_lock_res;
	logic wr_div_sel;
	logic wr_trim;
	logic wr_ena_mode;
	logic wr_phase_cmd;
	logic reg_step_fall;
	logic port_step_fall;

	assign wr_en = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
	assign rd_en = i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack;
	assign div_sel_all = {div_a_input_select, div_b_input_select,
		div_c_input_select, div_d_input_select};
	assign next_div_cmd = i_wb_dat[3:0];
	// One decoded write strobe per register keeps the update blocks short
	assign wr_lock_res = wr_en && i_wb_adr == `POCR_OFS_LOCK_RES;
	assign wr_div_sel = wr_en && i_wb_adr == `POCR_OFS_DIV_SEL;
	assign wr_trim = wr_en && i_wb_adr == `POCR_OFS_TRIM;
	assign wr_ena_mode = wr_en && i_wb_adr == `POCR_OFS_ENA_MODE;
	assign wr_phase_cmd = wr_en && i_wb_adr == `POCR_OFS_PHASE_CMD;
	// Rewriting the command bit low, or leaving it high, is not a step
	assign reg_step_fall = wr_phase_cmd && phase_step_command[`POCR_STEP_CMD_BIT]
		&& !i_wb_dat[`POCR_STEP_CMD_BIT];
	assign port_step_fall = step_port_q && !i_phase_step_port;

	// Bus handshake: one ack per access, one cycle after the strobe
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_wb_ack <= 1'b0;
		end else begin
			o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
		end
	end

	// Lock resolution register
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			lock_resolution_select <= `POCR_RST_LOCK_RES;
		end else if (wr_lock_res) begin
			lock_resolution_select <= i_wb_dat[`POCR_LOCK_RES_MSB:`POCR_LOCK_RES_LSB];
		end
	end

	// Divider cascade selects
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			{div_a_input_select, div_b_input_select,
				div_c_input_select, div_d_input_select} <= `POCR_RST_DIV_SEL;
		end else if (wr_div_sel) begin
			{div_a_input_select, div_b_input_select,
				div_c_input_select, div_d_input_select} <= i_wb_dat;
		end
	end

	// Trim fields
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			primary_out_edge_trim <= `POCR_RST_TRIM;
			secondary_out_edge_trim <= `POCR_RST_TRIM;
		end else if (wr_trim) begin
			primary_out_edge_trim <= i_wb_dat[`POCR_TRIM_PRI_MSB:`POCR_TRIM_PRI_LSB];
			secondary_out_edge_trim <= i_wb_dat[`POCR_TRIM_SEC_MSB:`POCR_TRIM_SEC_LSB];
		end
	end

	// Enables, lock mode, phase source
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			output_enable_fuses <= `POCR_RST_OUT_EN;
			lock_mode_select <= pocr_pkg::POCR_LOCK_NORMAL;
			phase_control_source <= `POCR_RST_PHASE_SRC;
		end else if (wr_ena_mode) begin
			// Fuses stay writable; tools normally own them
			output_enable_fuses <= i_wb_dat[`POCR_OUT_EN_MSB:`POCR_OUT_EN_LSB];
			phase_control_source <= i_wb_dat[`POCR_PHASE_SRC_BIT];
			// Unsupported lock modes are dropped, keeping a known mode
			case (i_wb_dat[`POCR_LOCK_MODE_MSB:`POCR_LOCK_MODE_LSB])
				pocr_pkg::POCR_LOCK_NORMAL: begin
					lock_mode_select <= pocr_pkg::POCR_LOCK_NORMAL;
				end
				pocr_pkg::POCR_LOCK_STICKY: begin
					lock_mode_select <= pocr_pkg::POCR_LOCK_STICKY;
				end
				pocr_pkg::POCR_LOCK_NORMAL_ALT: begin
					lock_mode_select <= pocr_pkg::POCR_LOCK_NORMAL_ALT;
				end
				default: begin
					lock_mode_select <= lock_mode_select;
				end
			endcase
		end
	end

	// Phase command register: step bit, direction, target output
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			phase_step_command <= `POCR_RST_PHASE_CMD;
		end else if (wr_phase_cmd) begin
			phase_step_command <= next_div_cmd;
		end
	end

	// Read data
	always_comb begin
		next_rd_dat = 8'h00;
		case (i_wb_adr)
			`POCR_OFS_LOCK_RES: begin
				next_rd_dat = {lock_resolution_select, 6'h00};
			end
			`POCR_OFS_DIV_SEL: begin
				next_rd_dat = div_sel_all;
			end
			`POCR_OFS_TRIM: begin
				next_rd_dat = {primary_out_edge_trim, secondary_out_edge_trim};
			end
			`POCR_OFS_ENA_MODE: begin
				next_rd_dat = {phase_control_source, lock_mode_select, output_enable_fuses};
			end
			`POCR_OFS_PHASE_CMD: begin
				next_rd_dat = {4'h0, phase_step_command};
			end
			`POCR_OFS_STATUS: begin
				next_rd_dat = {5'h00, phase_control_source, lock_held, o_lock};
			end
			default: begin
				next_rd_dat = 8'h00;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_wb_dat <= 8'h00;
		end else if (rd_en) begin
			o_wb_dat <= next_rd_dat;
		end
	end

	// Lock tolerance from resolution code
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_lock_tol_ppm <= `POCR_LOCK_PPM_0;
		end else begin
			case (lock_resolution_select)
				2'h0: o_lock_tol_ppm <= `POCR_LOCK_PPM_0;
				2'h1: o_lock_tol_ppm <= `POCR_LOCK_PPM_1;
				2'h2: o_lock_tol_ppm <= `POCR_LOCK_PPM_2;
				default: o_lock_tol_ppm <= `POCR_LOCK_PPM_3;
			endcase
		end
	end

	// Sticky lock; PLL reset or power down clears it even against a new lock
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			lock_held <= 1'b0;
		end else if (i_pll_rst || i_pll_pd
			|| lock_mode_select != pocr_pkg::POCR_LOCK_STICKY) begin
			lock_held <= 1'b0;
		end else if (i_lock_raw) begin
			lock_held <= 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_lock <= 1'b0;
		end else if (i_pll_rst || i_pll_pd) begin
			o_lock <= 1'b0;
		end else begin
			o_lock <= i_lock_raw || lock_held;
		end
	end

	// Divider input sources, one-hot: bit 0 pre-mux, bit n+1 divider n
	function automatic logic [4:0] div_src(input int unsigned k, input logic [1:0] sel);
		logic [4:0] src;
		src = 5'h01;
		case (sel)
			2'h1: src = (k == 0) ? 5'h10 : 5'h02;
			2'h2: src = (k == 0) ? 5'h04 : ((k == 1) ? 5'h10 : 5'h04);
			2'h3: src = (k == 3) ? 5'h08 : ((k == 2) ? 5'h10 : 5'h08);
			default: src = 5'h01;
		endcase
		return src;
	endfunction : div_src

	genvar gk;
	generate
		for (gk = 0; gk < 4; gk++) begin : g_div
			always_ff @(posedge i_clk_sys) begin
				if (!i_rst_n) begin
					o_div_src[gk*5 +: 5] <= 5'h01;
				end else begin
					o_div_src[gk*5 +: 5] <= div_src(gk, div_sel_all[(3-gk)*2 +: 2]);
				end
			end
		end
	endgenerate

	// Output enables
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			// Primary stays enabled through reset, matching the fuse reset value
			o_out_en <= `POCR_RST_OUT_EN;
		end else begin
			o_out_en <= output_enable_fuses | i_out_en_port;
		end
	end

	// Trim decode; a code that is not one-hot applies no trim
	function automatic pocr_pkg::pocr_trim_s trim_dec(input logic [3:0] t);
		pocr_pkg::pocr_trim_s r;
		r = '0;
		case (t[2:0])
			`POCR_TRIM_70: r.delay_ps = `POCR_TRIM_STEP_PS;
			`POCR_TRIM_140: r.delay_ps = 16'(`POCR_TRIM_STEP_PS * 2);
			`POCR_TRIM_280: r.delay_ps = 16'(`POCR_TRIM_STEP_PS * 4);
			default: r.delay_ps = 16'h0000;
		endcase
		r.rise_edge = t[3] && (r.delay_ps != 16'h0000);
		r.fall_edge = !t[3] && (r.delay_ps != 16'h0000);
		return r;
	endfunction : trim_dec

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_trim_primary <= '0;
			o_trim_secondary <= '0;
		end else begin
			o_trim_primary <= trim_dec(primary_out_edge_trim);
			o_trim_secondary <= trim_dec(secondary_out_edge_trim);
		end
	end

	// Phase stepping: falling edge of the active source's step bit
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			step_port_q <= 1'b0;
		end else begin
			step_port_q <= i_phase_step_port;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_phase_from_ports <= `POCR_RST_PHASE_SRC;
			o_phase_step <= '0;
		end else begin
			o_phase_from_ports <= phase_control_source;
			o_phase_step <= '0;
			if (!phase_control_source) begin
				// Step of 45 degrees when the command bit is written from 1 to 0
				if (reg_step_fall) begin
					o_phase_step.step <= 1'b1;
					o_phase_step.earlier <= i_wb_dat[`POCR_STEP_DIR_BIT];
					o_phase_step.target <= i_wb_dat[`POCR_STEP_SEL_MSB:`POCR_STEP_SEL_LSB];
				end
			end else if (port_step_fall) begin
				o_phase_step.step <= 1'b1;
				o_phase_step.earlier <= i_phase_dir_port;
				o_phase_step.target <= i_phase_sel_port;
			end
		end
	end

endmodule : pocr_regs

// ### sim/pocr_ref_pkg.sv
/* Reference decode of the configuration fields for the bench.
 Assumes pocr_pkg is compiled first. */
package pocr_ref_pkg;
	function automatic logic [15:0] ppm(input logic [1:0] c);
		return 16'h00fa << (2 * c);
	endfunction : ppm
	// Source index per code, four codes of 3 bits per divider
	function automatic logic [19:0] dsrc(input logic [7:0] d);
		logic [47:0] t;
		logic [11:0] e;
		logic [19:0] r;
		t = 48'h6a0708888688;
		r = 20'h00000;
		for (int j = 0; j < 4; j++) begin
			e = t[47 - 12 * j -: 12];
			r[5 * j + e[3 * d[7 - 2 * j -: 2] +: 3]] = 1'b1;
		end
		return r;
	endfunction : dsrc
	function automatic pocr_pkg::pocr_trim_s trim(input logic [3:0] t);
		logic oh;
		oh = t[2:0] inside {3'h1, 3'h2, 3'h4};
		return {t[3] & oh, ~t[3] & oh, oh ? 16'h0046 * {13'h0000, t[2:0]} : 16'h0000};
	endfunction : trim
endpackage : pocr_ref_pkg

// ### sim/pocr_far_model.sv
/* Far side: PLL lock detector and external phase-step ports.
 Assumes the bench raises i_step_req for one cycle at a time. */
module pocr_far_model (
	// Bench commands
	input wire logic i_clk_sys,
	input wire logic i_lock_want,
	input wire logic i_step_req,
	input wire logic i_step_dir,
	input wire logic [1:0] i_step_sel,
	// Toward the block
	output logic o_lock_raw = 1'b0,
	output logic o_step_port = 1'b0,
	output logic o_dir_port = 1'b0,
	output logic [1:0] o_sel_port = 2'h0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] busy = 2'h0;
	always @(posedge i_clk_sys) begin
		o_lock_raw <= i_lock_want;
		o_step_port <= i_step_req;
		busy <= {busy[0], i_step_req};
		// Qualifiers are noise except around a step
		if (i_step_req) begin
			{o_dir_port, o_sel_port} <= {i_step_dir, i_step_sel};
		end else if (busy == 2'h0) begin
			{o_dir_port, o_sel_port} <= ~{o_dir_port, o_sel_port};
		end
	end
endmodule : pocr_far_model

// ### sim/pocr_regs_assertions.sv
/* Port checker for pocr_regs, bound below.
 Assumes bus writes at most every second cycle. */
module pocr_regs_assertions (
	// Clock, reset, bus
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [7:0] i_wb_dat,
	input wire logic o_wb_ack,
	// Lock
	input wire logic i_lock_raw,
	input wire logic i_pll_rst,
	input wire logic i_pll_pd,
	input wire logic o_lock,
	input wire logic [15:0] o_lock_tol_ppm,
	// Outputs
	input wire logic [19:0] o_div_src,
	input wire logic [3:0] i_out_en_port,
	input wire logic [3:0] o_out_en,
	input wire pocr_pkg::pocr_trim_s o_trim_primary,
	input wire pocr_pkg::pocr_trim_s o_trim_secondary,
	// Phase
	input wire logic i_phase_step_port,
	input wire logic o_phase_from_ports,
	input wire pocr_pkg::pocr_phase_step_s o_phase_step
);
	timeunit 1ns;
	timeprecision 1ns;
	logic wt;
	assign wt = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// Three edges covers either update edge of the derived outputs
	property p_ppm;
		logic [1:0] c;
		(wt && i_wb_adr == 8'h0d, c = i_wb_dat[7:6]) |-> ##3 o_lock_tol_ppm == pocr_ref_pkg::ppm(c);
	endproperty
	a_ppm: assert property (p_ppm) else $error("tolerance");
	property p_div;
		logic [7:0] d;
		(wt && i_wb_adr == 8'h0e, d = i_wb_dat) |-> ##3 o_div_src == pocr_ref_pkg::dsrc(d);
	endproperty
	a_div: assert property (p_div) else $error("divider source");
	property p_trim;
		logic [7:0] d;
		(wt && i_wb_adr == 8'h0f, d = i_wb_dat) |-> ##3 o_trim_primary == pocr_ref_pkg::trim(d[7:4])
			&& o_trim_secondary == pocr_ref_pkg::trim(d[3:0]);
	endproperty
	a_trim: assert property (p_trim) else $error("trim");
	property p_src;
		logic s;
		(wt && i_wb_adr == 8'h10, s = i_wb_dat[7]) |-> ##3 o_phase_from_ports == s;
	endproperty
	a_src: assert property (p_src) else $error("phase source");
	property p_en;
		$past(i_rst_n) |-> (o_out_en & $past(i_out_en_port)) == $past(i_out_en_port);
	endproperty
	a_en: assert property (p_en) else $error("enable port lost");
	property p_clr;
		$past(i_pll_rst) || $past(i_pll_pd) |-> !o_lock;
	endproperty
	a_clr: assert property (p_clr) else $error("lock not cleared");
	property p_rise;
		$rose(o_lock) |-> $past(i_lock_raw);
	endproperty
	a_rise: assert property (p_rise) else $error("lock without raw");
	property p_port;
		$fell(i_phase_step_port) && o_phase_from_ports |=> o_phase_step.step;
	endproperty
	a_port: assert property (p_port) else $error("port step lost");
	property p_only;
		o_phase_step.step && o_phase_from_ports |-> $past(i_phase_step_port, 2)
			&& !$past(i_phase_step_port);
	endproperty
	a_only: assert property (p_only) else $error("stray step");
	property p_pulse;
		o_phase_step.step |=> !o_phase_step.step;
	endproperty
	a_pulse: assert property (p_pulse) else $error("step too long");
	c_sticky: cover property (o_lock && !i_lock_raw);
	c_port: cover property (o_phase_step.step && o_phase_from_ports);
	c_read: cover property (o_wb_ack && !i_wb_we);
endmodule : pocr_regs_assertions

bind pocr_regs pocr_regs_assertions pocr_regs_assertions_i (.i_clk_sys, .i_rst_n, .i_wb_cyc,
	.i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat, .o_wb_ack, .i_lock_raw, .i_pll_rst, .i_pll_pd,
	.o_lock, .o_lock_tol_ppm, .o_div_src, .i_out_en_port, .o_out_en, .o_trim_primary,
	.o_trim_secondary, .i_phase_step_port, .o_phase_from_ports, .o_phase_step);

// ### sim/tb_top.sv
/* Self-checking bench for pocr_regs with the far-side model.
 Assumes a 10 MHz clock and a registered one-cycle bus acknowledge. */
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
	logic i_pll_rst = 1'b0, i_pll_pd = 1'b0, want = 1'b0, sreq = 1'b0, dir = 1'b0;
	logic o_wb_ack, o_lock, o_phase_from_ports, i_lock_raw, i_phase_step_port, i_phase_dir_port;
	logic [1:0] i_phase_sel_port, sel = 2'h0;
	logic [7:0] i_wb_adr = 8'h00, i_wb_dat = 8'h00, o_wb_dat, d;
	logic [3:0] i_out_en_port = 4'h0, o_out_en;
	logic [15:0] o_lock_tol_ppm;
	logic [19:0] o_div_src;
	logic [31:0] r;
	pocr_pkg::pocr_trim_s o_trim_primary, o_trim_secondary;
	pocr_pkg::pocr_phase_step_s o_phase_step;
	int err_total = 0, n_compared = 0, seed = 86;
	logic [7:0] rq[$];
	logic [3:0] sq[$];

	pocr_regs pocr_regs_i (.i_clk_sys, .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
		.i_wb_dat, .o_wb_dat, .o_wb_ack, .i_lock_raw, .i_pll_rst, .i_pll_pd, .o_lock,
		.o_lock_tol_ppm, .o_div_src, .i_out_en_port, .o_out_en, .o_trim_primary,
		.o_trim_secondary, .i_phase_step_port, .i_phase_dir_port, .i_phase_sel_port,
		.o_phase_from_ports, .o_phase_step);
	pocr_far_model pocr_far_model_i (.i_clk_sys, .i_lock_want(want), .i_step_req(sreq),
		.i_step_dir(dir), .i_step_sel(sel), .o_lock_raw(i_lock_raw),
		.o_step_port(i_phase_step_port), .o_dir_port(i_phase_dir_port),
		.o_sel_port(i_phase_sel_port));

	initial forever #50 i_clk_sys = ~i_clk_sys;

	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("Compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish
	task automatic tick(input int n = 1);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask : tick
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
		int n;
		tick();
		{i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} = {2'b11, w, a, v};
		n = 0;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 8);
		if (n >= 8) chk(1'b0, 1'b1);
		#1 {i_wb_cyc, i_wb_stb} = 2'b00;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rq.push_back(e);
		bus(1'b0, a, 8'h00);
	endtask : rd
	task automatic put(input logic [7:0] a, input logic [7:0] v);
		bus(1'b1, a, v);
		rd(a, v);
	endtask : put
	task automatic pstep();
		sreq = 1'b1;
		tick();
		sreq = 1'b0;
		tick(4);
	endtask : pstep

	always @(posedge i_clk_sys) begin
		if (o_wb_ack === 1'b1 && i_wb_we === 1'b0) chk(o_wb_dat, rq.pop_front());
		if (o_phase_step.step === 1'b1) chk(o_phase_step, sq.pop_front());
	end

	initial begin
		#2000000;
		err_total++;
		tally_and_finish();
	end

	initial begin
		tick(5);
		i_rst_n = 1'b1;
		r = $random(seed);
		i_out_en_port = r[3:0];
		tick(2);
		chk(o_lock_tol_ppm, 16'h00fa);
		chk(o_div_src, 20'h08421);
		chk(o_trim_primary, 18'h00000);
		chk(o_trim_secondary, 18'h00000);
		chk(o_out_en, 4'h1 | i_out_en_port);
		chk(o_phase_from_ports, 1'b0);
		rd(8'h0d, 8'h00);
		rd(8'h0e, 8'h00);
		rd(8'h0f, 8'h00);
		rd(8'h10, 8'h01);
		rd(8'h3c, 8'h00);
		for (int c = 0; c < 4; c++) begin
			put(8'h0d, {c[1:0], 6'h00});
			chk(o_lock_tol_ppm, pocr_ref_pkg::ppm(c[1:0]));
		end
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			d = (i < 4) ? {4{i[1:0]}} : r[7:0];
			put(8'h0e, d);
			chk(o_div_src, pocr_ref_pkg::dsrc(d));
		end
		for (int t = 0; t < 16; t++) begin
			d = {t[3:0], ~t[3:0]};
			put(8'h0f, d);
			chk(o_trim_primary, pocr_ref_pkg::trim(d[7:4]));
			chk(o_trim_secondary, pocr_ref_pkg::trim(d[3:0]));
		end
		repeat (4) begin
			r = $random(seed);
			i_out_en_port = r[7:4];
			put(8'h10, {4'h0, r[3:0]});
			chk(o_out_en, r[3:0] | r[7:4]);
		end
		for (int k = 0; k < 4; k++) begin
			d = (k == 1) ? 8'h01 : (k == 2) ? 8'h41 : 8'h11;
			put(8'h10, d);
			want = 1'b1;
			tick(3);
			chk(o_lock, 1'b1);
			want = 1'b0;
			tick(3);
			chk(o_lock, d[4]);
			if (d[4]) begin
				rd(8'h12, 8'h03);
				{i_pll_rst, i_pll_pd} = (k == 0) ? 2'b10 : 2'b01;
				tick();
				{i_pll_rst, i_pll_pd} = 2'b00;
				tick();
				chk(o_lock, 1'b0);
			end
		end
		// Unsupported mode code must leave the sticky mode in place
		bus(1'b1, 8'h10, 8'h29);
		rd(8'h10, 8'h19);
		put(8'h10, 8'h01);
		bus(1'b1, 8'h11, 8'h02);
		repeat (3) begin
			r = $random(seed);
			bus(1'b1, 8'h11, 8'h01);
			sq.push_back({1'b1, r[0], r[2:1]});
			bus(1'b1, 8'h11, {4'h0, r[2:1], r[0], 1'b0});
		end
		pstep();
		put(8'h10, 8'h81);
		chk(o_phase_from_ports, 1'b1);
		bus(1'b1, 8'h11, 8'h01);
		bus(1'b1, 8'h11, 8'h00);
		repeat (3) begin
			r = $random(seed);
			{dir, sel} = r[2:0];
			sq.push_back({1'b1, r[2:0]});
			pstep();
		end
		tick(4);
		chk(rq.size() + sq.size(), 20'h00000);
		tally_and_finish();
	end
endmodule : tb_top
